/* apb_host.sv */
`timescale 1ns/100ps
// Processor side bus master, one transfer per call
module apb_host (
  input wire logic clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out
);
  // Idle bus at time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h0;
    pwdata_out = 32'h0;
  end
  // Setup, access until ready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a; // Released lines show no stale value
    pwdata_out <= ~d;
  endtask
endmodule

/* interval_timer_pkg.sv */
package interval_timer_pkg;

  // Units in which a fixed period is given
  typedef enum logic [2:0] {
    UNIT_NS,
    UNIT_US,
    UNIT_MS,
    UNIT_SEC,
    UNIT_CLOCKS
  } period_unit_t;

  // Decoded register access kinds
  typedef enum logic [3:0] {
    ACC_NONE,
    ACC_STATUS,
    ACC_CONTROL,
    ACC_PERIOD_LO,
    ACC_PERIOD_HI,
    ACC_SNAP_LO,
    ACC_SNAP_HI,
    ACC_IRQ_STATUS,
    ACC_IRQ_CLEAR,
    ACC_IRQ_ENABLE
  } reg_access_t;

endpackage

/* interval_timer_props.sv */
`timescale 1ns/100ps
`include "interval_timer_regs.svh"
// Port checks for the watchdog setup, period counted in clocks
module interval_timer_props #(
  parameter longint unsigned PERIOD = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic timeout_pulse_out,
  input wire logic reset_request_out,
  input wire logic irq_out
);
  typedef struct packed {logic started; logic [7:0] gap;} mon_t;
  mon_t mon_reg;
  mon_t mon_next;
  logic wr;
  logic bad;
  assign wr = psel_in & penable_in & pwrite_in;
  assign bad = paddr_in[1:0] != 2'h0 || paddr_in > `TMR_IRQ_ENABLE_ADDR;
  // Start seen, cycles since last expiry
  always_comb begin
    mon_next = mon_reg;
    if (wr && paddr_in == `TMR_CONTROL_ADDR && pwdata_in[2]) mon_next.started = 1'b1;
    if (timeout_pulse_out) mon_next.gap = 8'h01;
    else if (mon_reg.gap != 8'hFF) mon_next.gap = mon_reg.gap + 8'h01;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) mon_reg <= '{started: 1'b0, gap: 8'hFF};
    else mon_reg <= mon_next;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_access;
    psel_in && penable_in;
  endsequence
  sequence s_expiry;
    timeout_pulse_out ##1 !timeout_pulse_out;
  endsequence
  chk_strobe_single: assert property (timeout_pulse_out |-> s_expiry)
    else $error("expiry strobe longer than one clock");
  chk_reset_single: assert property (reset_request_out |=> !reset_request_out)
    else $error("reset request longer than one clock");
  chk_pulse_pair: assert property (timeout_pulse_out == reset_request_out)
    else $error("reset request and strobe differ");
  chk_expiry_gap: assert property (timeout_pulse_out |-> {56'h0, mon_reg.gap} >= PERIOD)
    else $error("expiries closer than the period");
  chk_start_first: assert property (timeout_pulse_out |-> mon_reg.started)
    else $error("expiry before start written");
  chk_err_decode: assert property (s_access |-> pready_out && pslverr_out == bad)
    else $error("ready or error response wrong");
  chk_unmapped_zero: assert property (s_access ##0 (bad && !pwrite_in) |-> prdata_out == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_cause: assert property ($rose(irq_out) |-> timeout_pulse_out || $past(wr))
    else $error("interrupt rose without cause");
endmodule
bind interval_timer_watchdog interval_timer_props #(.PERIOD(PERIOD)) u_props (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .timeout_pulse_out(timeout_pulse_out), .reset_request_out(reset_request_out),
  .irq_out(irq_out));

/* interval_timer_regs.svh */
`ifndef INTERVAL_TIMER_REGS_SVH
`define INTERVAL_TIMER_REGS_SVH

// Register byte addresses (index times four)
`define TMR_STATUS_ADDR 12'h000
`define TMR_CONTROL_ADDR 12'h004
`define TMR_PERIOD_LO_ADDR 12'h008
`define TMR_PERIOD_HI_ADDR 12'h00C
`define TMR_SNAP_LO_ADDR 12'h010
`define TMR_SNAP_HI_ADDR 12'h014
`define TMR_IRQ_STATUS_ADDR 12'h018
`define TMR_IRQ_CLEAR_ADDR 12'h01C
`define TMR_IRQ_ENABLE_ADDR 12'h020

// Status field positions
`define TMR_ST_TIMEOUT_BIT 0
`define TMR_ST_RUN_BIT 1

// Control field positions
`define TMR_CT_IRQ_EN_BIT 0
`define TMR_CT_CONT_BIT 1
`define TMR_CT_START_BIT 2
`define TMR_CT_STOP_BIT 3

// Reset values
`define TMR_CONTROL_RST 4'h0
`define TMR_IRQ_EN_RST 2'h0

// Clock and period generation constants
`define TMR_CLOCK_FREQ_HZ 33333000
`define TMR_PERIOD_DEFAULT 1

`endif

/* interval_timer_watchdog.sv */
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "interval_timer_regs.svh"

module interval_timer_watchdog #(
  parameter bit FIXED_PERIOD = 1'b0,
  parameter bit SNAPSHOT = 1'b1,
  parameter bit ALWAYS_RUN = 1'b0,
  parameter bit TIMEOUT_PULSE = 1'b0,
  parameter bit RESET_OUTPUT = 1'b0,
  parameter longint unsigned PERIOD = `TMR_PERIOD_DEFAULT,
  parameter interval_timer_pkg::period_unit_t PERIOD_UNIT = interval_timer_pkg::UNIT_SEC,
  parameter longint unsigned CLOCK_FREQ = `TMR_CLOCK_FREQ_HZ
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic timeout_pulse_out,
  output logic reset_request_out,
  output logic irq_out
);
  import interval_timer_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Fixed downcount computed at elaboration

  function automatic logic [31:0] fixed_count(input longint unsigned per,
                                              input period_unit_t unit,
                                              input longint unsigned freq);
    longint unsigned prod;
    prod = 64'h0;
    unique case (unit)
      UNIT_CLOCKS: prod = per - 64'h1;
      UNIT_SEC: prod = per * freq;
      UNIT_MS: prod = (per * freq) / 64'h3E8;
      UNIT_US: prod = (per * freq) / 64'hF4240;
      UNIT_NS: prod = (per * freq) / 64'h3B9A_CA00;
    endcase
    return prod[31:0];
  endfunction

  localparam logic [31:0] PRELOAD_RST =
    FIXED_PERIOD ? fixed_count(PERIOD, PERIOD_UNIT, CLOCK_FREQ) : 32'h0000_0000;

  // Register address decode, used by read and write paths
  function automatic reg_access_t decode(input logic [11:0] addr);
    unique case (addr)
      `TMR_STATUS_ADDR: return ACC_STATUS;
      `TMR_CONTROL_ADDR: return ACC_CONTROL;
      `TMR_PERIOD_LO_ADDR: return ACC_PERIOD_LO;
      `TMR_PERIOD_HI_ADDR: return ACC_PERIOD_HI;
      `TMR_SNAP_LO_ADDR: return ACC_SNAP_LO;
      `TMR_SNAP_HI_ADDR: return ACC_SNAP_HI;
      `TMR_IRQ_STATUS_ADDR: return ACC_IRQ_STATUS;
      `TMR_IRQ_CLEAR_ADDR: return ACC_IRQ_CLEAR;
      `TMR_IRQ_ENABLE_ADDR: return ACC_IRQ_ENABLE;
      default: return ACC_NONE;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [3:0] control;
    logic [31:0] preload;
    logic [31:0] snap;
    logic timeout;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic [31:0] rdata;
    logic timeout_pulse;
    logic reset_request;
    logic irq;
  } regs_state_t;

  regs_state_t state_reg;
  regs_state_t state_next;
  reg_access_t acc;
  logic wr_en;
  logic rd_en;
  logic start_req;
  logic stop_req;
  logic period_wr;

  timer_ctl_if ctl ();

  timer_counter_core #(
    .FREE_RUN(ALWAYS_RUN),
    .RESET_PULSE(RESET_OUTPUT)
  ) u_core (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ctl(ctl)
  );

  //////////////////////////////////////////////////////////////////////
  // APB access strobes: zero wait states
  assign acc = decode(paddr_in);
  assign wr_en = psel_in & penable_in & pwrite_in;
  assign rd_en = psel_in & ~penable_in & ~pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & (acc == ACC_NONE);

  // Control event bits
  assign start_req = wr_en & (acc == ACC_CONTROL) & pwdata_in[`TMR_CT_START_BIT];
  assign stop_req = wr_en & (acc == ACC_CONTROL) & pwdata_in[`TMR_CT_STOP_BIT];
  assign period_wr = wr_en & ((acc == ACC_PERIOD_LO) | (acc == ACC_PERIOD_HI));

  // Commands to the counter core
  assign ctl.start_pulse = start_req;
  assign ctl.stop_pulse = stop_req;
  assign ctl.reload_pulse = period_wr;
  assign ctl.cont_mode = state_reg.control[`TMR_CT_CONT_BIT];
  assign ctl.preload = state_next.preload;

  //////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.timeout_pulse = 1'b0;
    state_next.reset_request = 1'b0;
    // Control register store
    if (wr_en && acc == ACC_CONTROL) begin
      state_next.control = pwdata_in[3:0];
    end
    if (!FIXED_PERIOD && wr_en && acc == ACC_PERIOD_LO) begin
      state_next.preload[15:0] = pwdata_in[15:0];
    end
    if (!FIXED_PERIOD && wr_en && acc == ACC_PERIOD_HI) begin
      state_next.preload[31:16] = pwdata_in[15:0];
    end
    if (FIXED_PERIOD) begin
      state_next.preload = PRELOAD_RST;
    end
    if (SNAPSHOT && wr_en && (acc == ACC_SNAP_LO || acc == ACC_SNAP_HI)) begin
      state_next.snap = ctl.count;
    end
    // any status write clears, set wins
    if (wr_en && acc == ACC_STATUS) begin
      state_next.timeout = 1'b0;
    end
    if (ctl.zero_pulse) begin
      state_next.timeout = 1'b1;
    end
    // Interrupt sticky bits: 0 timeout, 1 watchdog reset; set wins
    if (wr_en && acc == ACC_IRQ_CLEAR) begin
      state_next.irq_status = state_reg.irq_status & ~pwdata_in[1:0];
    end
    if (ctl.zero_pulse) begin
      state_next.irq_status[0] = 1'b1;
      state_next.irq_status[1] = RESET_OUTPUT;
    end
    if (wr_en && acc == ACC_IRQ_ENABLE) begin
      state_next.irq_enable = pwdata_in[1:0];
    end
    state_next.irq = (|(state_next.irq_status & state_next.irq_enable)) |
                     (state_next.timeout & state_next.control[`TMR_CT_IRQ_EN_BIT]);
    if (TIMEOUT_PULSE && ctl.zero_pulse) begin
      state_next.timeout_pulse = 1'b1;
    end
    if (RESET_OUTPUT && ctl.zero_pulse) begin
      state_next.reset_request = 1'b1;
    end
    // Read data captured in setup phase
    if (rd_en) begin
      state_next.rdata = 32'h0000_0000;
      unique case (acc)
        ACC_STATUS: state_next.rdata[1:0] = {ctl.running, state_reg.timeout};
        ACC_CONTROL: state_next.rdata[3:0] = state_reg.control;
        ACC_PERIOD_LO: state_next.rdata[15:0] = state_reg.preload[15:0];
        ACC_PERIOD_HI: state_next.rdata[15:0] = state_reg.preload[31:16];
        ACC_SNAP_LO: state_next.rdata[15:0] = state_reg.snap[15:0];
        ACC_SNAP_HI: state_next.rdata[15:0] = state_reg.snap[31:16];
        ACC_IRQ_STATUS: state_next.rdata[1:0] = state_reg.irq_status;
        ACC_IRQ_ENABLE: state_next.rdata[1:0] = state_reg.irq_enable;
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '{control: `TMR_CONTROL_RST, preload: PRELOAD_RST,
                     snap: 32'h0000_0000, timeout: 1'b0, irq_status: 2'h0,
                     irq_enable: `TMR_IRQ_EN_RST, rdata: 32'h0000_0000,
                     timeout_pulse: 1'b0, reset_request: 1'b0, irq: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Registered outputs
  assign prdata_out = state_reg.rdata;
  assign timeout_pulse_out = state_reg.timeout_pulse;
  assign reset_request_out = state_reg.reset_request;
  assign irq_out = state_reg.irq;
endmodule

/* interval_timer_watchdog_test.sv */
`timescale 1ns/100ps
`include "interval_timer_regs.svh"
module interval_timer_watchdog_test;
  localparam longint unsigned PER = 20;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, tpulse, rreq, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic psel_b, penable_b, pwrite_b, pready_b, pslverr_b;
  logic [11:0] paddr_b;
  logic [31:0] pwdata_b, prdata_b, prdata_c;
  int num_errors = 0;
  int num_checks = 0;
  int n, pulses = 0, p0;
  // Clock and expiry counter
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) if (tpulse === 1'b1) pulses++;
  apb_host host (.clk_in(clk_in), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  interval_timer_watchdog #(.FIXED_PERIOD(1'b1), .ALWAYS_RUN(1'b1), .TIMEOUT_PULSE(1'b1),
    .RESET_OUTPUT(1'b1), .PERIOD(PER), .PERIOD_UNIT(interval_timer_pkg::UNIT_CLOCKS)) DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .timeout_pulse_out(tpulse),
    .reset_request_out(rreq), .irq_out(irq));
  // Second bus serves two more builds: writable free run, fixed period with defaults
  apb_host host_b (.clk_in(clk_in), .prdata_in(prdata_b), .pready_in(pready_b),
    .pslverr_in(pslverr_b), .psel_out(psel_b), .penable_out(penable_b),
    .pwrite_out(pwrite_b), .paddr_out(paddr_b), .pwdata_out(pwdata_b));
  interval_timer_watchdog #(.SNAPSHOT(1'b0), .ALWAYS_RUN(1'b1)) dut_b (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_b), .penable_in(penable_b),
    .pwrite_in(pwrite_b), .paddr_in(paddr_b), .pwdata_in(pwdata_b), .prdata_out(prdata_b),
    .pready_out(pready_b), .pslverr_out(pslverr_b), .timeout_pulse_out(),
    .reset_request_out(), .irq_out());
  interval_timer_watchdog #(.FIXED_PERIOD(1'b1), .PERIOD(1)) dut_c (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_b), .penable_in(penable_b),
    .pwrite_in(pwrite_b), .paddr_in(paddr_b), .pwdata_in(pwdata_b), .prdata_out(prdata_c),
    .pready_out(), .pslverr_out(), .timeout_pulse_out(), .reset_request_out(), .irq_out());
  ////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task wr_b(input logic [11:0] a, input logic [31:0] d);
    host_b.xfer(1'b1, a, d, q, e);
  endtask
  task rd_b(input logic [11:0] a);
    host_b.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task wait_pulse(input int lim);
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (tpulse !== 1'b1 && n < lim);
  endtask
  task complete_run;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(`TMR_PERIOD_LO_ADDR); check("period_lo", q, 32'h13);
    rd(`TMR_PERIOD_HI_ADDR); check("period_hi", q, 32'h0);
    wr(`TMR_PERIOD_LO_ADDR, 32'hABCD);
    rd(`TMR_PERIOD_LO_ADDR); check("fixed_lo", q, 32'h13);
    wait_pulse(60); check("idle", n, 60);
    rd(`TMR_STATUS_ADDR); check("status_idle", q, 32'h0);
    wr(`TMR_IRQ_ENABLE_ADDR, 32'h3);
    wr(`TMR_CONTROL_ADDR, 32'h5);
    wait_pulse(40);
    wait_pulse(40); check("gap", n, PER);
    check("reset_req", rreq, 1'b1);
    check("irq_on", irq, 1'b1);
    rd(`TMR_STATUS_ADDR); check("status_to", q, 32'h3);
    wr(`TMR_STATUS_ADDR, 32'h0);
    rd(`TMR_STATUS_ADDR); check("status_clr", q, 32'h2);
    wait_pulse(40);
    wr(`TMR_IRQ_ENABLE_ADDR, 32'h0);
    wr(`TMR_CONTROL_ADDR, 32'h4);
    wr(`TMR_STATUS_ADDR, 32'h0);
    rd(`TMR_IRQ_STATUS_ADDR); check("irq_sticky", q, 32'h3);
    check("irq_masked", irq, 1'b0);
    wait_pulse(40);
    wr(`TMR_IRQ_CLEAR_ADDR, 32'h3);
    rd(`TMR_IRQ_STATUS_ADDR); check("irq_clear", q, 32'h0);
    wr(`TMR_CONTROL_ADDR, 32'h8);
    wait_pulse(40); check("no_stop", n < 21, 1'b1);
    p0 = pulses + 1; // Strobe now high is counted at the next edge
    // Kick before each expiry
    repeat (10) begin
      repeat (8) @(posedge clk_in);
      wr(`TMR_PERIOD_HI_ADDR, 32'h1234);
    end
    check("kicked", pulses, p0);
    wait_pulse(40); check("reload", n > 18 && n < 24, 1'b1);
    // Kick then capture: two cycles after reload the count is 17
    wr(`TMR_PERIOD_LO_ADDR, 32'h0);
    wr(`TMR_SNAP_HI_ADDR, 32'h0);
    rd(`TMR_SNAP_LO_ADDR); check("snap_lo", q, 32'h11);
    rd(`TMR_SNAP_HI_ADDR); check("snap_hi", q, 32'h0);
    rd(`TMR_PERIOD_HI_ADDR); check("fixed_hi", q, 32'h0);
    rd(12'h040); check("unmapped", {q[30:0], e}, 32'h1);
    // Writable free-running build, and fixed period in default units
    rd_b(`TMR_STATUS_ADDR); check("b_run", q[1], 1'b1);
    rd_b(`TMR_PERIOD_LO_ADDR); check("c_fixed_lo", prdata_c, 32'h9F08);
    rd_b(`TMR_PERIOD_HI_ADDR); check("c_fixed_hi", prdata_c, 32'h01FC);
    wr_b(`TMR_PERIOD_LO_ADDR, 32'h5A5A);
    wr_b(`TMR_PERIOD_HI_ADDR, 32'hA5A5);
    rd_b(`TMR_PERIOD_LO_ADDR); check("b_period_lo", q, 32'h5A5A);
    rd_b(`TMR_PERIOD_HI_ADDR); check("b_period_hi", q, 32'hA5A5);
    check("c_kept_hi", prdata_c, 32'h01FC);
    wr_b(`TMR_CONTROL_ADDR, 32'h8);
    rd_b(`TMR_STATUS_ADDR); check("b_no_stop", q[1], 1'b1);
    complete_run;
  end
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk_in);
    num_errors++;
    complete_run;
  end
endmodule

/* timer_counter_core.sv */
`timescale 1ns/100ps

module timer_counter_core #(
  parameter bit FREE_RUN = 1'b0,
  parameter bit RESET_PULSE = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  timer_ctl_if.core ctl
);
  import interval_timer_pkg::*;

  typedef struct packed {
    logic [31:0] count;
    logic running;
    logic zero;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  // Counter reset value: running after reset only when free running without the reset pulse
  localparam logic RUN_AT_RESET = FREE_RUN & ~RESET_PULSE;
  // Once started, nothing halts a free-running or watchdog counter
  localparam logic NO_HALT = FREE_RUN | RESET_PULSE;

  //////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.zero = 1'b0;
    if (ctl.reload_pulse) begin
      state_next.count = ctl.preload;
      // Period write stops the count unless it may never halt
      if (!NO_HALT) begin
        state_next.running = 1'b0;
      end
    end else if (state_reg.running) begin
      if (state_reg.count == 32'h0000_0000) begin
        state_next.count = ctl.preload;
        state_next.zero = 1'b1;
        if (!ctl.cont_mode && !NO_HALT) begin
          state_next.running = 1'b0;
        end
      end else begin
        state_next.count = state_reg.count - 32'h0000_0001;
      end
    end
    if (ctl.start_pulse && (!FREE_RUN || RESET_PULSE)) begin
      state_next.running = 1'b1;
    end
    // stop ignored when halting is barred
    if (ctl.stop_pulse && !NO_HALT && !ctl.start_pulse) begin
      state_next.running = 1'b0;
    end
    // free running without reset pulse never stops
    if (RUN_AT_RESET) begin
      state_next.running = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '{count: 32'h0000_0000, running: RUN_AT_RESET, zero: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign ctl.count = state_reg.count;
  assign ctl.running = state_reg.running;
  assign ctl.zero_pulse = state_reg.zero;
endmodule

/* timer_ctl_if.sv */
`timescale 1ns/100ps

// Commands from the register bank to the counter core, and its state back
interface timer_ctl_if;
  logic start_pulse;
  logic stop_pulse;
  logic reload_pulse;
  logic cont_mode;
  logic [31:0] preload;
  logic [31:0] count;
  logic running;
  logic zero_pulse;

  modport regs (
    output start_pulse, stop_pulse, reload_pulse, cont_mode, preload,
    input count, running, zero_pulse
  );
  modport core (
    input start_pulse, stop_pulse, reload_pulse, cont_mode, preload,
    output count, running, zero_pulse
  );
endinterface
